// *** design/cbo_pkg.sv ***
// Overview of operation
// - Auto-disable plus signal loss forces outputs low.
// - Auto-disable bit resets to enabled.
// - Auto-disable off: outputs follow static input.
// - Sticky loss flag, cleared by writing one.
// - Live loss bit shows unlatched detector state.
// - Configuration bit switches input 50 ohm terminations.
// - Coupling bit: AC turns input bias on.
// - Read-only vendor, device and revision identifiers.
// - Power-good low means power-down; high runs.
// - Block read returns byte-counter number of bytes.
// - Swing code spans 600 to 975 mV.
// - One register enable bit per clock output.
// - Mask bit set: sideband cannot touch output.
// - Read-only bits show each enable pin level.
// - Four-bit slew codes, 0x0 fastest, 0xF slowest.
// - Per-output selector picks option, resets to second.
// - Slew options reset to 0x0, 0x6, 0xA, 0xF.
// - Low on active-low enable pin allows output.
// - Slew pin low slow, high fast.
// - Sideband active only if strap high at power-up.
// - Eight shifted bits move to enables on latch.
// - Status bit reports sideband mode at power-up.
// - Sideband mode: four shared enable pins ignored.
// - Two three-level straps select nine SMBus addresses.
// - Loss status pin low while loss detected.
package cbo_pkg;
  localparam int        NOUT         = 8;
  localparam logic [7:0] REG_INCFG   = 8'h00;
  localparam logic [7:0] REG_OUTEN   = 8'h01;
  localparam logic [7:0] REG_MASK    = 8'h02;
  localparam logic [7:0] REG_OEPIN   = 8'h03;
  localparam logic [7:0] REG_SWING   = 8'h04;
  localparam logic [7:0] REG_SLEW12  = 8'h05;
  localparam logic [7:0] REG_SLEW34  = 8'h06;
  localparam logic [7:0] REG_SEL_LO  = 8'h07;
  localparam logic [7:0] REG_SEL_HI  = 8'h08;
  localparam logic [7:0] REG_VENDOR  = 8'h09;
  localparam logic [7:0] REG_DEVICE  = 8'h0A;
  localparam logic [7:0] REG_REV     = 8'h0B;
  localparam logic [7:0] REG_BCNT    = 8'h0C;
  localparam int        CFG_TERM     = 0;
  localparam int        CFG_AC       = 1;
  localparam int        CFG_AOD      = 2;
  localparam int        CFG_LOSEV    = 3;
  localparam int        CFG_LOSLIVE  = 4;
  localparam int        CFG_SBMODE   = 5;
  localparam logic       RST_AOD     = 1'b1;
  localparam logic [7:0] RST_OUTEN   = 8'hFF;
  localparam logic [3:0] RST_SWING   = 4'h8;
  localparam logic [3:0] RST_OPT1    = 4'h0;
  localparam logic [3:0] RST_OPT2    = 4'h6;
  localparam logic [3:0] RST_OPT3    = 4'hA;
  localparam logic [3:0] RST_OPT4    = 4'hF;
  localparam logic [1:0] RST_SEL     = 2'h1;
  localparam logic [7:0] RST_BCNT    = 8'h0D;
  localparam logic [7:0] RST_SIDEBAND_STRAP    = 8'hFF;
  localparam logic [7:0] IDLE_BYTE   = 8'hFF;
  localparam logic [1:0] SLOW_OPT    = 2'h2;
  localparam logic [7:0] SB_SHARED_OE = 8'h36;
  localparam logic [1:0] INIT_CYCLES = 2'h3;
  localparam logic [2:0] LAST_BIT    = 3'h7;
  // Strap index is high*3+low, each strap 0 low, 1 mid, 2 high.
  localparam logic [8:0][6:0] SMB_ADDR_TBL = {7'h67, 7'h66, 7'h65, 7'h63, 7'h62, 7'h61,
                                             7'h6F, 7'h6D, 7'h6C};
  typedef enum logic [2:0] {
    SMB_IDLE, SMB_RX, SMB_ACK, SMB_ACKHOLD, SMB_TX, SMB_RACK, SMB_RNEXT
  } cbo_smb_e;
  typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_COUNT, PH_DATA} cbo_ph_e;
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       clk;
    logic       input_signal_loss;
    logic       sbclk;
    logic       sbdat;
    logic       sblat_n;
    logic       pwrgd;
    logic       slew;
    logic [7:0] oe_n;
    logic       sbstrap;
    logic [1:0] astr_lo;
    logic [1:0] astr_hi;
  } cbo_pins_s;
  typedef struct packed {
    cbo_pins_s       s1;
    cbo_pins_s       s2;
    logic            scl_p;
    logic            sda_p;
    logic            sbclk_p;
    logic            lat_p;
    logic            los_p;
    logic [1:0]      init_cnt;
    logic            strap_done;
    logic            sb_mode;
    logic [6:0]      addr;
    cbo_smb_e        st;
    cbo_ph_e         ph;
    logic [2:0]      bcnt;
    logic [7:0]      sh;
    logic            rw;
    logic [7:0]      ptr;
    logic [7:0]      rleft;
    logic            rfirst;
    logic            sda_oe;
    logic            term;
    logic            acb;
    logic            auto_output_disable;
    logic            los_ev;
    logic [7:0]      out_en_reg;
    logic [7:0]      mask;
    logic [3:0]      swing;
    logic [3:0][3:0] opt;
    logic [7:0][1:0] sel;
    logic [7:0]      bcnt_reg;
    logic [7:0]      sb_sh;
    logic [7:0]      sb_en;
    logic            sb_out;
    logic [7:0]      gate;
    logic [7:0]      clk_out;
    logic [31:0]     slew;
    logic            los_n;
    logic            pd;
  } cbo_state_s;
endpackage

// *** design/cbo_top.sv ***
module cbo_top
  import cbo_pkg::*;
#(
  parameter logic [7:0] VENDOR_ID = 8'h5A,  // Arbitrary value.
  parameter logic [7:0] DEVICE_ID = 8'h3C,  // Arbitrary value.
  parameter logic [7:0] REV_ID    = 8'h01   // Arbitrary value.
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        smb_scl_i,
  input  wire logic        smb_sda_i,
  output logic             smb_sda_o,
  output logic             smb_sda_oe_o,
  input  wire logic        ref_clk_i,
  input  wire logic        input_signal_loss_i,
  input  wire logic        powergood_powerdown_n_i,
  input  wire logic        edge_speed_select_pin_i,
  input  wire logic [7:0]  oe_n_i,
  input  wire logic        sideband_strap_i,
  input  wire logic [1:0]  addr_strap_low_i,
  input  wire logic [1:0]  addr_strap_high_i,
  input  wire logic        sideband_serial_port_clk_i,
  input  wire logic        sideband_serial_port_data_i,
  input  wire logic        shift_latch_n_i,
  output logic             sideband_serial_port_out_o,
  output logic [7:0]       clk_o,
  output logic             signal_loss_flag_n_o,
  output logic             power_down_o,
  output logic             term_en_o,
  output logic             ac_bias_o,
  output logic [3:0]       differential_swing_o,
  output logic [31:0]      edge_speed_option_o
);

  cbo_state_s q;
  cbo_state_s d;
  cbo_pins_s  pin_in;
  logic       los_clr;

  assign pin_in = '{scl: smb_scl_i, sda: smb_sda_i, clk: ref_clk_i,
                    input_signal_loss: input_signal_loss_i, sbclk: sideband_serial_port_clk_i,
                    sbdat: sideband_serial_port_data_i, sblat_n: shift_latch_n_i,
                    pwrgd: powergood_powerdown_n_i, slew: edge_speed_select_pin_i,
                    oe_n: oe_n_i, sbstrap: sideband_strap_i,
                    astr_lo: addr_strap_low_i, astr_hi: addr_strap_high_i};

  // A strap left floating above the high level is read as high.
  function automatic logic [6:0] strap_addr(input logic [1:0] hi, input logic [1:0] lo);
    logic [3:0] h;
    logic [3:0] l;
    h = (hi > 2'h2) ? 4'h2 : {2'h0, hi};
    l = (lo > 2'h2) ? 4'h2 : {2'h0, lo};
    return SMB_ADDR_TBL[4'(h * 4'h3 + l)];
  endfunction

  function automatic logic [7:0] reg_read(input cbo_state_s s, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      REG_INCFG: begin
        v[CFG_TERM]    = s.term;
        v[CFG_AC]      = s.acb;
        v[CFG_AOD]     = s.auto_output_disable;
        v[CFG_LOSEV]   = s.los_ev;
        v[CFG_LOSLIVE] = s.s2.input_signal_loss;
        v[CFG_SBMODE]  = s.sb_mode;
      end
      REG_OUTEN:  v = s.out_en_reg;
      REG_MASK:   v = s.mask;
      REG_OEPIN:  v = s.s2.oe_n;
      REG_SWING:  v = {4'h0, s.swing};
      REG_SLEW12: v = {s.opt[1], s.opt[0]};
      REG_SLEW34: v = {s.opt[3], s.opt[2]};
      REG_SEL_LO: v = s.sel[3:0];
      REG_SEL_HI: v = s.sel[7:4];
      REG_VENDOR: v = VENDOR_ID;
      REG_DEVICE: v = DEVICE_ID;
      REG_REV:    v = REV_ID;
      REG_BCNT:   v = s.bcnt_reg;
      default:    v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic cbo_state_s reg_write(input cbo_state_s s, input logic [7:0] idx,
                                           input logic [7:0] v);
    cbo_state_s r;
    r = s;
    case (idx)
      REG_INCFG: begin
        r.term   = v[CFG_TERM];
        r.acb    = v[CFG_AC];
        r.auto_output_disable    = v[CFG_AOD];
        r.los_ev = s.los_ev & ~v[CFG_LOSEV];
      end
      REG_OUTEN:  r.out_en_reg = v;
      REG_MASK:   r.mask = v;
      REG_SWING:  r.swing = v[3:0];
      REG_SLEW12: r.opt[1:0] = v;
      REG_SLEW34: r.opt[3:2] = v;
      REG_SEL_LO: r.sel[3:0] = v;
      REG_SEL_HI: r.sel[7:4] = v;
      REG_BCNT:   r.bcnt_reg = v;
      default:    r = s;
    endcase
    return r;
  endfunction

  logic       scl_r;
  logic       scl_f;
  logic       smb_start;
  logic       smb_stop;
  logic       sb_shift;
  logic       sb_latch;
  logic       los_now;
  logic       force_off;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [7:0] oe_ok;
  logic [7:0] sb_ok;
  logic [7:0] want;
  logic       do_load;

  always_comb begin
    d         = q;
    los_clr   = 1'b0;
    do_load   = 1'b0;
    tx_byte   = IDLE_BYTE;
    d.s1      = pin_in;
    d.s2      = q.s1;
    d.scl_p   = q.s2.scl;
    d.sda_p   = q.s2.sda;
    d.sbclk_p = q.s2.sbclk;
    d.lat_p   = q.s2.sblat_n;
    d.los_p   = q.s2.input_signal_loss;
    scl_r     = q.s2.scl & ~q.scl_p;
    scl_f     = ~q.s2.scl & q.scl_p;
    smb_start = q.s2.scl & q.scl_p & q.sda_p & ~q.s2.sda;
    smb_stop  = q.s2.scl & q.scl_p & ~q.sda_p & q.s2.sda;
    rx_byte   = {q.sh[6:0], q.s2.sda};

    // Straps are caught once, after the synchronisers have settled.
    if (!q.strap_done) begin
      if (q.init_cnt == INIT_CYCLES) begin
        d.strap_done = 1'b1;
        d.sb_mode    = q.s2.sbstrap;
        d.addr       = strap_addr(q.s2.astr_hi, q.s2.astr_lo);
      end else begin
        d.init_cnt = 2'(q.init_cnt + 2'h1);
      end
    end

    if (smb_start) begin
      d.st     = SMB_RX;
      d.ph     = PH_ADDR;
      d.bcnt   = 3'h0;
      d.sda_oe = 1'b0;
    end else if (smb_stop) begin
      d.st     = SMB_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        SMB_RX: begin
          if (scl_r) begin
            d.sh   = rx_byte;
            d.bcnt = 3'(q.bcnt + 3'h1);
            if (q.bcnt == LAST_BIT) begin
              d.st = SMB_ACK;
              case (q.ph)
                PH_ADDR: begin
                  if (rx_byte[7:1] == q.addr && q.strap_done) begin
                    d.rw     = rx_byte[0];
                    d.ph     = PH_CMD;
                    d.rfirst = 1'b1;
                    d.rleft  = q.bcnt_reg;
                  end else begin
                    d.st = SMB_IDLE;
                  end
                end
                PH_CMD: begin
                  d.ptr = rx_byte;
                  d.ph  = PH_COUNT;
                end
                PH_COUNT: d.ph = PH_DATA;
                default: begin
                  d     = reg_write(d, q.ptr, rx_byte);
                  los_clr = (q.ptr == REG_INCFG) & rx_byte[CFG_LOSEV];
                  d.ptr = 8'(q.ptr + 8'h1);
                end
              endcase
            end
          end
        end
        SMB_ACK: begin
          if (scl_f) begin
            d.sda_oe = 1'b1;
            d.st     = SMB_ACKHOLD;
          end
        end
        SMB_ACKHOLD: begin
          if (scl_f) begin
            d.sda_oe = 1'b0;
            if (q.rw) begin
              do_load = 1'b1;
            end else begin
              d.st   = SMB_RX;
              d.bcnt = 3'h0;
            end
          end
        end
        SMB_TX: begin
          if (scl_r) begin
            d.bcnt = 3'(q.bcnt + 3'h1);
            if (q.bcnt == LAST_BIT) begin
              d.st = SMB_RACK;
            end
          end else if (scl_f) begin
            d.sh     = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
        SMB_RACK: begin
          if (scl_f) begin
            d.sda_oe = 1'b0;
          end else if (scl_r) begin
            d.st = q.s2.sda ? SMB_IDLE : SMB_RNEXT;
          end
        end
        SMB_RNEXT: begin
          if (scl_f) begin
            do_load = 1'b1;
          end
        end
        default: d.st = SMB_IDLE;
      endcase
    end

    // Block read: the count byte leads, then that many registers, then filler.
    if (do_load) begin
      if (q.rfirst) begin
        tx_byte = q.bcnt_reg;
      end else if (q.rleft != 8'h00) begin
        tx_byte = reg_read(q, q.ptr);
        d.ptr   = 8'(q.ptr + 8'h1);
        d.rleft = 8'(q.rleft - 8'h1);
      end
      d.rfirst = 1'b0;
      d.sh     = tx_byte;
      d.sda_oe = ~tx_byte[7];
      d.bcnt   = 3'h0;
      d.st     = SMB_TX;
    end

    // A loss edge in the same cycle as its clear keeps the flag set.
    if (q.s2.input_signal_loss & ~q.los_p) begin
      d.los_ev = 1'b1;
    end

    // Sideband shift and latch run only when the strap was high at power-up.
    sb_shift = q.sb_mode & q.s2.sbclk & ~q.sbclk_p;
    sb_latch = q.sb_mode & q.lat_p & ~q.s2.sblat_n;
    if (sb_shift) begin
      d.sb_sh  = {q.sb_sh[6:0], q.s2.sbdat};
      d.sb_out = q.sb_sh[7];
    end
    if (sb_latch) begin
      d.sb_en = q.sb_sh;
    end

    los_now   = q.s2.input_signal_loss;
    force_off = (q.auto_output_disable & los_now) | ~q.s2.pwrgd;
    oe_ok     = ~q.s2.oe_n | (q.sb_mode ? SB_SHARED_OE : 8'h00);
    sb_ok     = q.mask | ~{NOUT{q.sb_mode}} | q.sb_en;
    want      = oe_ok & q.out_en_reg & sb_ok;
    // A lost or powered-down input may sit high, so forcing off cannot wait.
    if (force_off) begin
      d.gate = 8'h00;
    end else if (!q.s2.clk) begin
      d.gate = want;
    end
    // With auto-disable off a static input still passes straight through.
    d.clk_out = {NOUT{q.s2.clk}} & q.gate;
    for (int i = 0; i < NOUT; i++) begin
      d.slew[i*4 +: 4] = q.s2.slew ? q.opt[q.sel[i]] : q.opt[SLOW_OPT];
    end
    d.los_n = ~los_now;
    d.pd    = ~q.s2.pwrgd;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q            <= '0;
      q.auto_output_disable        <= RST_AOD;
      q.out_en_reg <= RST_OUTEN;
      q.swing      <= RST_SWING;
      q.opt        <= {RST_OPT4, RST_OPT3, RST_OPT2, RST_OPT1};
      q.sel        <= {NOUT{RST_SEL}};
      q.bcnt_reg   <= RST_BCNT;
      q.sb_en      <= RST_SIDEBAND_STRAP;
      q.los_n      <= 1'b1;
      q.pd         <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign smb_sda_o                  = 1'b0;
  assign smb_sda_oe_o               = q.sda_oe;
  assign sideband_serial_port_out_o = q.sb_out;
  assign clk_o                      = q.clk_out;
  assign signal_loss_flag_n_o       = q.los_n;
  assign power_down_o               = q.pd;
  assign term_en_o                  = q.term;
  assign ac_bias_o                  = q.acb;
  assign differential_swing_o       = q.swing;
  assign edge_speed_option_o        = q.slew;

  a_aod_forces_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (q.auto_output_disable && q.s2.input_signal_loss) |=> ##1 (clk_o == 8'h00))
    else $error("outputs not low after loss with auto-disable on");
  a_aod_reset_on: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> q.auto_output_disable)
    else $error("auto-disable not enabled out of reset");
  a_follow_static: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!q.auto_output_disable && q.s2.pwrgd && q.gate == 8'hFF) |=> (clk_o == {8{$past(q.s2.clk)}}))
    else $error("outputs do not follow input with auto-disable off");
  a_los_sticky: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (q.los_ev && !los_clr) |=> q.los_ev)
    else $error("loss flag dropped without a clear");
  a_los_pin: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(q.s2.input_signal_loss) |=> ##[0:1] !signal_loss_flag_n_o)
    else $error("loss status pin not low during loss");
  a_pd_outputs: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!q.s2.pwrgd) |=> (power_down_o && q.gate == 8'h00) ##1 (clk_o == 8'h00))
    else $error("power-down did not stop outputs");
  a_sb_latch: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (q.sb_mode && q.lat_p && !q.s2.sblat_n) |=> (q.sb_en == $past(q.sb_sh)))
    else $error("latch pulse did not load sideband enables");
  a_sb_inactive: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!q.sb_mode && q.strap_done) |=> $stable(q.sb_en) && $stable(q.sb_sh))
    else $error("sideband changed while not in sideband mode");
  a_slew_slow_pin: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!q.s2.slew) |=> (edge_speed_option_o[3:0] == $past(q.opt[2])))
    else $error("slow pin did not select slow option");
  a_gate_clk_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ($rose(q.gate[0]) || ($fell(q.gate[0]) && !$past(force_off))) |-> !$past(q.s2.clk))
    else $error("output gate changed while clock high");
  c_los_event: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(q.los_ev));
  c_block_read: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    (q.st == SMB_TX) ##1 (q.st == SMB_RACK));
  c_sb_latch: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    q.sb_mode && $changed(q.sb_en));
  c_follow_no_aod: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    !q.auto_output_disable && q.s2.input_signal_loss && (clk_o != 8'h00));
  c_mask_kept: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    q.sb_mode && (q.mask != 8'h00) && $changed(q.sb_en));
  a_los_sets_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(q.s2.input_signal_loss) |=> q.los_ev)
    else $error("loss edge did not set the sticky flag");
  // A clear that meets a fresh loss edge must lose, so only a quiet cycle is checked here.
  a_los_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (q.los_ev && los_clr && !(q.s2.input_signal_loss && !q.los_p)) |=> !q.los_ev)
    else $error("write of one did not clear the loss flag");
  a_loss_pin_high: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !q.s2.input_signal_loss |=> signal_loss_flag_n_o)
    else $error("loss status pin low without loss");
  a_power_pin: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    q.s2.pwrgd |=> !power_down_o)
    else $error("power-down shown while power is good");
  a_slew_fast_pin: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    q.s2.slew |=> (edge_speed_option_o[3:0] == $past(q.opt[q.sel[0]])))
    else $error("fast pin did not select the chosen option");
  a_strap_once: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    q.strap_done |=> $stable(q.sb_mode) && $stable(q.addr))
    else $error("strap state changed after it was caught");
endmodule

// *** bench/cbo_far_model.sv ***
module cbo_far_model (
  input  wire logic mclk_i,
  input  wire logic dev_sda_oe_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      sb_clk_o,
  output logic      sb_dat_o,
  output logic      sb_lat_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       pull;
  logic       nack;
  logic [7:0] rx [0:15];
  // Open-drain wire with a pull-up: low when either party pulls it.
  assign sda_o = ~(pull | dev_sda_oe_i);
  initial begin
    scl_o = 1'b1;
    pull = 1'b0;
    nack = 1'b0;
    sb_clk_o = 1'b0;
    sb_dat_o = 1'b0;
    sb_lat_n_o = 1'b1;
  end
  // Half periods of 10 mclk keep the bus well above the oversampling limit.
  task automatic hp();
    repeat (10) @(negedge mclk_i);
  endtask
  task automatic bit_out(input logic b);
    pull = ~b;
    hp();
    scl_o = 1'b1;
    hp();
    scl_o = 1'b0;
  endtask
  task automatic byte_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    pull = 1'b0;
    hp();
    scl_o = 1'b1;
    if (sda_o !== 1'b0) nack = 1'b1;
    hp();
    scl_o = 1'b0;
  endtask
  task automatic byte_in(input logic last, output logic [7:0] b);
    pull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      hp();
      scl_o = 1'b1;
      b[i] = sda_o;
      hp();
      scl_o = 1'b0;
    end
    bit_out(last);
  endtask
  task automatic start();
    pull = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    pull = 1'b1;
    hp();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    pull = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    pull = 1'b0;
    hp();
  endtask
  task automatic smb_write(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d);
    start();
    byte_out({a, 1'b0});
    byte_out(idx);
    byte_out(8'h01);
    byte_out(d);
    stop();
  endtask
  // The first byte read back is the count, then n register bytes.
  task automatic smb_read(input logic [6:0] a, input logic [7:0] idx, input int n);
    start();
    byte_out({a, 1'b0});
    byte_out(idx);
    start();
    byte_out({a, 1'b1});
    for (int i = 0; i <= n; i++) byte_in(i == n, rx[i]);
    stop();
  endtask
  task automatic w8();
    repeat (8) @(negedge mclk_i);
  endtask
  // Output 7 goes first so that it ends up in the top bit.
  task automatic sb_send(input logic [7:0] en);
    for (int i = 7; i >= 0; i--) begin
      sb_dat_o = en[i];
      w8();
      sb_clk_o = 1'b1;
      w8();
      sb_clk_o = 1'b0;
    end
    sb_dat_o = ~en[0];
    w8();
    sb_lat_n_o = 1'b0;
    w8();
    sb_lat_n_o = 1'b1;
    w8();
  endtask
endmodule

// *** bench/test_clock_buffer_output_control.sv ***
module test_clock_buffer_output_control
  import cbo_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] VEN  = 8'hA5;  // Arbitrary value.
  localparam logic [7:0] DEV  = 8'h4B;  // Arbitrary value.
  localparam logic [7:0] REV  = 8'h02;  // Arbitrary value.
  localparam logic [6:0] ADDR = 7'h62;
  logic        mclk_i, rstn_i, ref_clk, loss, pwrgd, slew, strap, sda_oe, sb_out;
  logic [7:0]  oe_n, clk_o;
  logic [3:0]  swing;
  logic [31:0] slew_code;
  logic        los_n, pd, term, acb;
  logic [1:0]  astr_lo, astr_hi;
  logic [6:0]  smb_addr;
  wire         scl, sda, sb_clk, sb_dat, sb_lat_n;
  int          bad_count, n_tests, cycles;
  logic [7:0]  rv [0:12];

  cbo_far_model host (.mclk_i(mclk_i), .dev_sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda),
    .sb_clk_o(sb_clk), .sb_dat_o(sb_dat), .sb_lat_n_o(sb_lat_n));
  cbo_top #(.VENDOR_ID(VEN), .DEVICE_ID(DEV), .REV_ID(REV)) uut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .smb_scl_i(scl), .smb_sda_i(sda), .smb_sda_o(),
    .smb_sda_oe_o(sda_oe), .ref_clk_i(ref_clk), .input_signal_loss_i(loss),
    .powergood_powerdown_n_i(pwrgd), .edge_speed_select_pin_i(slew), .oe_n_i(oe_n),
    .sideband_strap_i(strap), .addr_strap_low_i(astr_lo), .addr_strap_high_i(astr_hi),
    .sideband_serial_port_clk_i(sb_clk), .sideband_serial_port_data_i(sb_dat),
    .shift_latch_n_i(sb_lat_n), .sideband_serial_port_out_o(sb_out), .clk_o(clk_o),
    .signal_loss_flag_n_o(los_n), .power_down_o(pd), .term_en_o(term), .ac_bias_o(acb),
    .differential_swing_o(swing), .edge_speed_option_o(slew_code));

  always #2.5 mclk_i = ~mclk_i;
  // The input clock is offset so its edges never meet an mclk edge.
  initial begin
    ref_clk = 1'b0;
    #0.1;
    forever #32 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Records which outputs were seen high over more than fifteen input periods.
  task automatic watch(input logic [7:0] exp);
    logic [7:0] s;
    s = 8'h00;
    repeat (30) @(negedge mclk_i);
    repeat (200) @(negedge mclk_i) s = s | clk_o;
    chk(s, exp);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.smb_write(smb_addr, idx, d);
    repeat (10) @(negedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    host.smb_read(smb_addr, idx, 1);
    chk(host.rx[1], exp);
  endtask

  task automatic t_reset();
    rv = '{8'h04, 8'hFF, 8'h00, 8'h00, 8'h08, 8'h60, 8'hFA, 8'h55, 8'h55, VEN, DEV, REV, 8'h0D};
    host.smb_read(ADDR, REG_INCFG, 13);
    chk(host.rx[0], 8'h0D);
    for (int i = 0; i < 13; i++) chk(host.rx[i + 1], rv[i]);
    chk(slew_code, 32'h66666666);
    @(negedge mclk_i) slew = 1'b0;
    repeat (10) @(negedge mclk_i);
    chk(slew_code, 32'hAAAAAAAA);
    @(negedge mclk_i) slew = 1'b1;
    host.nack = 1'b0;
    host.smb_write(7'h6C, REG_SWING, 8'h03);
    chk(host.nack, 1'b1);
  endtask

  task automatic t_config();
    host.nack = 1'b0;
    wr(REG_INCFG, 8'h07);
    chk({term, acb}, 2'b11);
    wr(REG_INCFG, 8'h04);
    chk({term, acb}, 2'b00);
    wr(REG_SWING, 8'h0F);
    chk(swing, 4'hF);
    wr(REG_SEL_LO, 8'hE4);
    repeat (10) @(negedge mclk_i);
    chk(slew_code[15:0], 16'hFA60);
    chk(host.nack, 1'b0);
    wr(REG_BCNT, 8'h02);
    host.smb_read(ADDR, 8'h20, 2);
    chk({host.rx[0], host.rx[1], host.rx[2]}, 24'h020000);
  endtask

  task automatic t_enables();
    @(negedge mclk_i) oe_n = 8'h0F;
    wr(REG_OUTEN, 8'h3C);
    rd(REG_OEPIN, 8'h0F);
    watch(8'h30);
    @(negedge mclk_i) oe_n = 8'h00;
    wr(REG_OUTEN, 8'hFF);
    watch(8'hFF);
  endtask

  task automatic t_los();
    @(negedge mclk_i) loss = 1'b1;
    repeat (10) @(negedge mclk_i);
    chk(los_n, 1'b0);
    watch(8'h00);
    rd(REG_INCFG, 8'h1C);
    @(negedge mclk_i) loss = 1'b0;
    repeat (10) @(negedge mclk_i);
    chk(los_n, 1'b1);
    rd(REG_INCFG, 8'h0C);
    wr(REG_INCFG, 8'h0C);
    rd(REG_INCFG, 8'h04);
    wr(REG_INCFG, 8'h00);
    @(negedge mclk_i) loss = 1'b1;
    watch(8'hFF);
    @(negedge mclk_i) loss = 1'b0;
    wr(REG_INCFG, 8'h0C);
    rd(REG_INCFG, 8'h04);
  endtask

  task automatic t_power();
    @(negedge mclk_i) pwrgd = 1'b0;
    repeat (10) @(negedge mclk_i);
    chk(pd, 1'b1);
    watch(8'h00);
    @(negedge mclk_i) pwrgd = 1'b1;
    repeat (10) @(negedge mclk_i);
    chk(pd, 1'b0);
    watch(8'hFF);
  endtask

  task automatic t_sideband();
    host.sb_send(8'h00);
    watch(8'hFF);
    wr(REG_INCFG, 8'h00);
    // A second power-up with the strap high brings the serial port to life.
    @(negedge mclk_i) rstn_i = 1'b0;
    strap = 1'b1;
    astr_lo = 2'h2;
    astr_hi = 2'h2;
    smb_addr = 7'h67;
    repeat (3) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (12) @(negedge mclk_i);
    rd(REG_INCFG, 8'h24);
    host.nack = 1'b0;
    host.smb_write(ADDR, REG_SWING, 8'h03);
    chk(host.nack, 1'b1);
    @(negedge mclk_i) oe_n = 8'h37;
    wr(REG_MASK, 8'h02);
    host.sb_send(8'hA5);
    watch(8'hA6);
    // The last bit pushed out of the chain is the low bit of the previous frame.
    host.sb_send(8'h58);
    chk(sb_out, 1'b1);
    watch(8'h5A);
  endtask

  initial begin
    mclk_i = 1'b0;
    rstn_i = 1'b0;
    loss = 1'b0;
    pwrgd = 1'b1;
    slew = 1'b1;
    strap = 1'b0;
    astr_lo = 2'h1;
    astr_hi = 2'h1;
    smb_addr = ADDR;
    oe_n = 8'h00;
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i) rstn_i = 1'b1;
    repeat (12) @(negedge mclk_i);
    t_reset();
    t_config();
    t_enables();
    t_los();
    t_power();
    t_sideband();
    give_verdict();
  end
endmodule
